// ---- design/vbc_pkg.sv ----
package vbc_pkg;

  // Register offsets (subaddress values)
  localparam logic [7:0] OFS_CHAN_ONE   = 8'h01;
  localparam logic [7:0] OFS_CHAN_TWO   = 8'h02;
  localparam logic [7:0] OFS_CHAN_THREE = 8'h03;
  localparam logic [7:0] OFS_SYNC_CTRL  = 8'h04;

  // Channel register fields
  localparam int CH_FILT_BIT = 7;
  localparam int CH_MUX_HI   = 6;
  localparam int CH_MUX_LO   = 3;
  localparam int CH_MODE_HI  = 2;
  localparam int CH_MODE_LO  = 0;

  // Sync and master-control register fields
  localparam int SC_RSVD_BIT = 7;
  localparam int SC_MON_BIT  = 6;
  localparam int SC_BUF_BIT  = 5;
  localparam int SC_VSEL_HI  = 4;
  localparam int SC_VSEL_LO  = 3;
  localparam int SC_HSEL_HI  = 2;
  localparam int SC_HSEL_LO  = 1;
  localparam int SC_SYNC_BIT = 0;

  // Mode codes
  localparam logic [2:0] MODE_OFF      = 3'h0;
  localparam logic [2:0] MODE_MUTE     = 3'h1;
  localparam logic [2:0] MODE_DC       = 3'h2;
  localparam logic [2:0] MODE_DC_SHIFT = 3'h3;
  localparam logic [2:0] MODE_AC_BIAS  = 3'h4;
  localparam logic [2:0] MODE_CLAMP_LO = 3'h5;
  localparam logic [2:0] MODE_CLAMP_MD = 3'h6;
  localparam logic [2:0] MODE_CLAMP_HI = 3'h7;

  // Mux code limits: input B band, everything above is reserved
  localparam logic [3:0] MUX_B_FIRST = 4'h5;
  localparam logic [3:0] MUX_B_LAST  = 4'h9;
  localparam logic [1:0] SYNC_SEL_B  = 2'h1;

  // Power-up values chosen by the strap
  localparam logic [7:0] RST_CHAN      = 8'h00;
  localparam logic [7:0] RST_CTRL      = 8'h00;
  localparam logic [7:0] STRAP_HI_CHAN = 8'h04;
  localparam logic [7:0] STRAP_HI_CTRL = 8'h40;

  // Serial bus slave address, upper five bits fixed
  localparam logic [4:0] DEV_ADDR_FIXED = 5'h0B;

  // Timing counts: init steps in clk cycles, bit counts in scl rising edges
  localparam logic [1:0] INIT_LOAD     = 2'h2;
  localparam logic [1:0] INIT_DONE     = 2'h3;
  localparam logic [3:0] BIT_ACK_DRIVE = 4'h8;
  localparam logic [3:0] BIT_ACK_DONE  = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_SUB   = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6,
    ST_WAIT  = 3'h7
  } vbc_state_t;

  // Sync mux decode: only code 01 picks input B, reserved codes fall to A
  function automatic logic sync_pick_b(input logic [1:0] code);
    sync_pick_b = (code == SYNC_SEL_B);
  endfunction

endpackage

// ---- design/vbc_chan_if.sv ----
`timescale 1ns/100ps
interface vbc_chan_if;
  logic [7:0] cfg;
  logic       mon_master;
  logic       buf_master;
  logic       monitor_en;
  logic       buffer_en;
  logic       mute;
  logic       input_b;
  logic       clamp_wide;
  logic [2:0] mode;

  modport bank   (output cfg, mon_master, buf_master,
                  input  monitor_en, buffer_en, mute, input_b, clamp_wide, mode);
  modport decode (input  cfg, mon_master, buf_master,
                  output monitor_en, buffer_en, mute, input_b, clamp_wide, mode);
endinterface

// ---- design/vbc_chan_decode.sv ----
`timescale 1ns/100ps
module vbc_chan_decode (
  vbc_chan_if.decode ch
);
  import vbc_pkg::*;

  logic [2:0] mode_code;
  logic [3:0] mux_code;
  logic       paths_on;

  // Field split and per-channel decode
  always_comb begin
    mode_code     = ch.cfg[CH_MODE_HI:CH_MODE_LO];
    mux_code      = ch.cfg[CH_MUX_HI:CH_MUX_LO];
    paths_on      = (mode_code != MODE_OFF);
    ch.mode       = mode_code;
    ch.mute       = (mode_code == MODE_MUTE);
    ch.monitor_en = paths_on && ch.mon_master;
    ch.buffer_en  = paths_on && ch.buf_master;
    ch.input_b    = (mux_code >= MUX_B_FIRST) && (mux_code <= MUX_B_LAST);
    ch.clamp_wide = ch.cfg[CH_FILT_BIT] &&
                    (mode_code >= MODE_CLAMP_LO);
  end

endmodule

// ---- design/vbc_reg_bank.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - Channel bit 7 picks the narrow clamp filter when 0 and the wide one when 1.
// - The filter bit only counts in the three clamped ac modes and is ignored otherwise.
// - Mode 000 turns off both paths of the channel, and mode 001 mutes it.
// - Modes 010, 011 and 100 give dc, dc with shift and ac with fixed bias.
// - Modes 101, 110 and 111 give the clamped ac mode with low, mid and high bias.
// - Each channel register steers only its own channel with the same layout.
// - Control bit 7 is reserved and steers nothing.
// - Control bit 6 low forces every monitor path off, high lets each follow its mode.
// - Control bit 5 low forces every buffer path off, high lets each follow its mode.
// - Control bits 4 and 3 pick the vertical sync input, 01 meaning B and all else A.
// - Control bits 2 and 1 pick the horizontal sync input, 01 meaning B and all else A.
// - Control bit 0 enables both sync paths when 1 and disables them when 0.
// - A write is start, address, subaddress, one data byte and stop, with no bursts.
// - A read sets the subaddress in one transaction and returns one byte in the next.
// - After power-up the strap low gives all off, high gives monitors on and ac bias.
module vbc_reg_bank (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       address_select_high_pin,
  input  wire logic       address_select_low_pin,
  input  wire logic       power_up_strap,
  output logic [2:0]      monitor_en,
  output logic [2:0]      buffer_en,
  output logic [2:0]      chan_mute,
  output logic [2:0]      chan_input_b,
  output logic [2:0]      clamp_filter_wide,
  output logic [8:0]      chan_mode,
  output logic            vsync_input_b,
  output logic            hsync_input_b,
  output logic            sync_paths_en
);
  import vbc_pkg::*;

  // Pin synchronisers: scl, sda, two address pins, strap
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic [1:0] bus_prev_reg;
  logic       scl_s;
  logic       sda_s;
  logic       start_seen;
  logic       stop_seen;
  logic       scl_rise;
  logic       scl_fall;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_reg   <= 5'h1F;
      pin_s2_reg   <= 5'h1F;
      bus_prev_reg <= 2'h3;
    end else begin
      pin_s1_reg   <= {power_up_strap, address_select_high_pin, address_select_low_pin,
                       scl_in, sda_in};
      pin_s2_reg   <= pin_s1_reg;
      bus_prev_reg <= pin_s2_reg[1:0];
    end
  end

  // Bus condition detection on the synchronised lines
  assign scl_s      = pin_s2_reg[1];
  assign sda_s      = pin_s2_reg[0];
  assign start_seen = scl_s && bus_prev_reg[1] && bus_prev_reg[0] && !sda_s;
  assign stop_seen  = scl_s && bus_prev_reg[1] && !bus_prev_reg[0] && sda_s;
  assign scl_rise   = scl_s && !bus_prev_reg[1];
  assign scl_fall   = !scl_s && bus_prev_reg[1];

  // Slave and register state
  vbc_state_t state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic       rw_reg, rw_next;
  logic [2:0] sub_reg, sub_next;
  logic       pend_reg, pend_next;
  logic [7:0] pdata_reg, pdata_next, rd_byte;
  logic       oe_n_reg, oe_n_next;
  logic [1:0] init_reg, init_next;
  logic [7:0] chan_reg [0:2];
  logic [7:0] chan_next [0:2];
  logic [7:0] ctrl_reg, ctrl_next;

  // Register read mux; unmapped subaddresses read as zero
  function automatic logic [7:0] read_sel(input logic [2:0] sub);
    case ({5'h00, sub})
      OFS_CHAN_ONE:   read_sel = chan_reg[0];
      OFS_CHAN_TWO:   read_sel = chan_reg[1];
      OFS_CHAN_THREE: read_sel = chan_reg[2];
      OFS_SYNC_CTRL:  read_sel = ctrl_reg;
      default:        read_sel = 8'h00;
    endcase
  endfunction
  // Byte offered on a read, picked by the stored subaddress
  assign rd_byte = read_sel(sub_reg);

  // Next-state logic for the serial slave and the register bank
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    rw_next    = rw_reg;
    sub_next   = sub_reg;
    pend_next  = pend_reg;
    pdata_next = pdata_reg;
    oe_n_next  = oe_n_reg;
    init_next  = init_reg;
    chan_next  = chan_reg;
    ctrl_next  = ctrl_reg;
    // Strap is caught once it has crossed the synchroniser
    if (init_reg != INIT_DONE) begin
      init_next = init_reg + 2'h1;
      if (init_reg == INIT_LOAD && pin_s2_reg[4]) begin
        chan_next = '{STRAP_HI_CHAN, STRAP_HI_CHAN, STRAP_HI_CHAN};
        ctrl_next = STRAP_HI_CTRL;
      end
    end
    if (start_seen) begin
      state_next = ST_ADDR;
      cnt_next   = 4'h0;
      oe_n_next  = 1'b1;
      pend_next  = 1'b0;
    end else if (stop_seen) begin
      // A write lands only when the transaction closes with stop
      if (pend_reg) begin
        case ({5'h00, sub_reg})
          OFS_CHAN_ONE:   chan_next[0] = pdata_reg;
          OFS_CHAN_TWO:   chan_next[1] = pdata_reg;
          OFS_CHAN_THREE: chan_next[2] = pdata_reg;
          default:        ctrl_next    = pdata_reg;
        endcase
      end
      state_next = ST_IDLE;
      pend_next  = 1'b0;
      oe_n_next  = 1'b1;
    end else if (scl_rise) begin
      if (state_reg == ST_ADDR || state_reg == ST_SUB || state_reg == ST_WDATA) begin
        if (cnt_reg < BIT_ACK_DRIVE) begin
          shift_next = {shift_reg[6:0], sda_s};
        end
      end
      if (state_reg != ST_IDLE && state_reg != ST_WAIT) begin
        cnt_next = cnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      case (state_reg)
        ST_ADDR: begin
          if (cnt_reg == BIT_ACK_DRIVE) begin
            if (shift_reg[7:1] == {DEV_ADDR_FIXED, pin_s2_reg[3], pin_s2_reg[2]}) begin
              rw_next   = shift_reg[0];
              oe_n_next = 1'b0;
            end else begin
              state_next = ST_WAIT;
            end
          end else if (cnt_reg == BIT_ACK_DONE) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              state_next = ST_RDATA;
              shift_next = rd_byte;
              oe_n_next  = rd_byte[7];
            end else begin
              state_next = ST_SUB;
              oe_n_next  = 1'b1;
            end
          end
        end
        ST_SUB: begin
          if (cnt_reg == BIT_ACK_DRIVE) begin
            if (shift_reg >= OFS_CHAN_ONE && shift_reg <= OFS_SYNC_CTRL) begin
              sub_next  = shift_reg[2:0];
              oe_n_next = 1'b0;
            end else begin
              state_next = ST_WAIT;
            end
          end else if (cnt_reg == BIT_ACK_DONE) begin
            cnt_next   = 4'h0;
            oe_n_next  = 1'b1;
            state_next = ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (cnt_reg == BIT_ACK_DRIVE) begin
            pdata_next = shift_reg;
            pend_next  = 1'b1;
            oe_n_next  = 1'b0;
          end else if (cnt_reg == BIT_ACK_DONE) begin
            oe_n_next  = 1'b1;
            state_next = ST_WAIT;
          end
        end
        ST_RDATA: begin
          if (cnt_reg < BIT_ACK_DRIVE) begin
            shift_next = {shift_reg[6:0], 1'b0};
            oe_n_next  = shift_reg[6];
          end else if (cnt_reg == BIT_ACK_DRIVE) begin
            oe_n_next  = 1'b1;
          end else begin
            state_next = ST_WAIT;
          end
        end
        ST_IDLE, ST_WAIT: begin
          oe_n_next = 1'b1;
        end
        default: begin
          state_next = ST_IDLE;
          oe_n_next  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg    <= 1'b0;
      sub_reg   <= 3'h0;
      pend_reg  <= 1'b0;
      pdata_reg <= 8'h00;
      oe_n_reg  <= 1'b1;
      init_reg  <= 2'h0;
      chan_reg  <= '{RST_CHAN, RST_CHAN, RST_CHAN};
      ctrl_reg  <= RST_CTRL;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      rw_reg    <= rw_next;
      sub_reg   <= sub_next;
      pend_reg  <= pend_next;
      pdata_reg <= pdata_next;
      oe_n_reg  <= oe_n_next;
      init_reg  <= init_next;
      chan_reg  <= chan_next;
      ctrl_reg  <= ctrl_next;
    end
  end

  // Per-channel decode, one instance per channel with the same layout
  vbc_chan_if ch_if [3] ();

  for (genvar g = 0; g < 3; g++) begin : g_chan
    assign ch_if[g].cfg        = chan_reg[g];
    assign ch_if[g].mon_master = ctrl_reg[SC_MON_BIT];
    assign ch_if[g].buf_master = ctrl_reg[SC_BUF_BIT];
    vbc_chan_decode u_dec (
      .ch (ch_if[g])
    );
  end

  // Decoded controls collected into next values; control bit 7 is only read back on the bus
  logic [2:0] mon_next, buf_next, mute_next, inb_next, filt_next;
  logic [8:0] mode_next;

  always_comb begin
    mon_next  = {ch_if[2].monitor_en, ch_if[1].monitor_en, ch_if[0].monitor_en};
    buf_next  = {ch_if[2].buffer_en,  ch_if[1].buffer_en,  ch_if[0].buffer_en};
    mute_next = {ch_if[2].mute,       ch_if[1].mute,       ch_if[0].mute};
    inb_next  = {ch_if[2].input_b,    ch_if[1].input_b,    ch_if[0].input_b};
    filt_next = {ch_if[2].clamp_wide, ch_if[1].clamp_wide, ch_if[0].clamp_wide};
    mode_next = {ch_if[2].mode,       ch_if[1].mode,       ch_if[0].mode};
  end

  // Output registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_out           <= 1'b0;
      sda_oe_n          <= 1'b1;
      monitor_en        <= 3'h0;
      buffer_en         <= 3'h0;
      chan_mute         <= 3'h0;
      chan_input_b      <= 3'h0;
      clamp_filter_wide <= 3'h0;
      chan_mode         <= 9'h000;
      vsync_input_b     <= 1'b0;
      hsync_input_b     <= 1'b0;
      sync_paths_en     <= 1'b0;
    end else begin
      sda_out           <= 1'b0;                            // Open drain: only pulls low
      sda_oe_n          <= oe_n_reg;
      monitor_en        <= mon_next;
      buffer_en         <= buf_next;
      chan_mute         <= mute_next;
      chan_input_b      <= inb_next;
      clamp_filter_wide <= filt_next;
      chan_mode         <= mode_next;
      vsync_input_b     <= sync_pick_b(ctrl_reg[SC_VSEL_HI:SC_VSEL_LO]);
      hsync_input_b     <= sync_pick_b(ctrl_reg[SC_HSEL_HI:SC_HSEL_LO]);
      sync_paths_en     <= ctrl_reg[SC_SYNC_BIT];
    end
  end

endmodule

// ---- testbench/vbc_reg_bank_sva.sv ----
`timescale 1ns/100ps
module vbc_reg_bank_sva (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_oe_n,
  input wire logic       power_up_strap,
  input wire logic [2:0] monitor_en,
  input wire logic [2:0] buffer_en,
  input wire logic [2:0] chan_mute,
  input wire logic [2:0] clamp_filter_wide,
  input wire logic [8:0] chan_mode,
  input wire logic       vsync_input_b,
  input wire logic       sync_paths_en
);
  logic [2:0] is_off;
  logic [2:0] is_mute;
  logic [2:0] clampable;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Per channel mode classes
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      is_off[i]    = chan_mode[3*i+:3] == 3'h0;
      is_mute[i]   = chan_mode[3*i+:3] == 3'h1;
      clampable[i] = chan_mode[3*i+:3] >= 3'h5;
    end
  end

  a_clamp_mode_gate: assert property ((clamp_filter_wide & ~clampable) == 3'h0)
    else $error("wide clamp filter outside clamped modes");
  a_mute_code: assert property (chan_mute == is_mute)
    else $error("mute does not follow mode 001");
  a_off_monitor: assert property ((monitor_en & is_off) == 3'h0)
    else $error("monitor on in off mode");
  a_off_buffer: assert property ((buffer_en & is_off) == 3'h0)
    else $error("buffer on in off mode");
  a_monitor_uniform: assert property (monitor_en != 3'h0 |-> monitor_en == ~is_off)
    else $error("monitor paths disagree with master");
  a_buffer_uniform: assert property (buffer_en != 3'h0 |-> buffer_en == ~is_off)
    else $error("buffer paths disagree with master");
  a_change_idle_bus: assert property ($changed({chan_mode, monitor_en}) |-> scl_in && sda_in)
    else $error("outputs changed outside the stop");
  a_answer_clock_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("data line moved while clock high");
  a_answer_held: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("data line pull too short");
  a_power_up_state: assert property ($rose(resetn) |-> ##6
    (monitor_en == {3{power_up_strap}} && buffer_en == 3'h0
    && chan_mode == {3{power_up_strap, 2'h0}} && !sync_paths_en))
    else $error("power-up state wrong");

  c_mute: cover property (chan_mute != 3'h0);
  c_wide: cover property (clamp_filter_wide != 3'h0);
  c_vsync_b: cover property (vsync_input_b);
  c_answer: cover property ($fell(sda_oe_n));
endmodule

bind vbc_reg_bank vbc_reg_bank_sva chk (
  .clk               (clk),
  .resetn            (resetn),
  .scl_in            (scl_in),
  .sda_in            (sda_in),
  .sda_oe_n          (sda_oe_n),
  .power_up_strap    (power_up_strap),
  .monitor_en        (monitor_en),
  .buffer_en         (buffer_en),
  .chan_mute         (chan_mute),
  .clamp_filter_wide (clamp_filter_wide),
  .chan_mode         (chan_mode),
  .vsync_input_b     (vsync_input_b),
  .sync_paths_en     (sync_paths_en)
);

// ---- testbench/vbc_host_model.sv ----
`timescale 1ns/100ps
module vbc_host_model (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_line
);
  // Each wait step lasts this many clk periods; clock high is one step, clock low two
  localparam int PH = 6;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_ph();
    repeat (PH) @(negedge clk);
  endtask

  // Start: data falls while clock high
  task automatic start();
    wait_ph();
    sda_drv = 1'b0;
    wait_ph();
    scl = 1'b0;
  endtask

  // Stop: data rises while clock high, then idle
  task automatic stop();
    wait_ph();
    sda_drv = 1'b0;
    wait_ph();
    scl = 1'b1;
    wait_ph();
    sda_drv = 1'b1;
    wait_ph();
    wait_ph();
  endtask

  // Data set in clock low, sampled at the end of clock high
  task automatic bit_io(input logic b, output logic r);
    wait_ph();
    sda_drv = b;
    wait_ph();
    scl = 1'b1;
    wait_ph();
    r = sda_line;
    scl = 1'b0;
  endtask

  // MSB first byte, ninth bit released: ack in, nack out on reads
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    ack = !a;
  endtask
endmodule

// ---- testbench/vbc_reg_bank_tb.sv ----
`timescale 1ns/100ps
module vbc_reg_bank_tb;
  import vbc_pkg::*;
  logic       clk, resetn, strap, a_hi, a_lo, sda_oe_n, sda_out, vsb, hsb, spe, scl, sda_m;
  logic [2:0] mon, bfe, mut, inb, cwd;
  logic [8:0] mode;
  wire        sda_line = sda_m & (sda_oe_n | sda_out);
  int         error_cnt, total_checks, seed;
  int         model [5];

  vbc_reg_bank dut (
    .clk(clk), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_select_high_pin(a_hi), .address_select_low_pin(a_lo),
    .power_up_strap(strap), .monitor_en(mon), .buffer_en(bfe), .chan_mute(mut),
    .chan_input_b(inb), .clamp_filter_wide(cwd), .chan_mode(mode),
    .vsync_input_b(vsb), .hsync_input_b(hsb), .sync_paths_en(spe)
  );
  vbc_host_model host (.clk(clk), .scl(scl), .sda_drv(sda_m), .sda_line(sda_line));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Decoded outputs worked out from the register model
  task automatic chk_out();
    logic [2:0] m, b, u, ib, w;
    logic [8:0] md;
    logic [7:0] c, s;
    s = model[4];
    for (int i = 0; i < 3; i++) begin
      c = model[i+1];
      md[3*i+:3] = c[2:0];
      m[i] = s[6] && c[2:0] != 3'h0;
      b[i] = s[5] && c[2:0] != 3'h0;
      u[i] = c[2:0] == 3'h1;
      ib[i] = c[6:3] >= 4'h5 && c[6:3] <= 4'h9;
      w[i] = c[7] && c[2:0] >= 3'h5;
    end
    check({m, b, u, ib, w, md, s[4:3] == 2'h1, s[2:1] == 2'h1, s[0]},
          {mon, bfe, mut, inb, cwd, mode, vsb, hsb, spe});
  endtask

  function automatic logic [7:0] adr(input logic rw);
    return {DEV_ADDR_FIXED, a_hi, a_lo, rw};
  endfunction

  // One transaction of n bytes, expected ack per byte in acks
  task automatic send(input logic [31:0] by, input int n, input logic [3:0] acks);
    logic [7:0] q;
    logic       ak;
    host.start();
    for (int i = 0; i < n; i++) begin
      host.xbyte(by[31-8*i-:8], q, ak);
      check(acks[3-i], ak);
    end
    host.stop();
    repeat (4) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] sub, input logic [7:0] d);
    logic ok;
    ok = sub >= 8'h01 && sub <= 8'h04;
    send({adr(1'b0), sub, d, 8'h00}, 3, {1'b1, ok, ok, 1'b0});
    if (ok) model[sub] = d;
    chk_out();
  endtask

  task automatic rd(input logic [7:0] sub);
    logic [7:0] q;
    logic       ak;
    send({adr(1'b0), sub, 16'h0000}, 2, 4'hC);
    host.start();
    host.xbyte(adr(1'b1), q, ak);
    check(1'b1, ak);
    host.xbyte(8'hFF, q, ak);
    check(model[sub], q);
    host.stop();
  endtask

  task automatic rst(input logic s);
    resetn = 1'b0;
    strap = s;
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    repeat (12) @(negedge clk);
    model = '{0, 4 * s, 4 * s, 4 * s, 64 * s};
    chk_out();
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Watchdog on the whole run
  initial begin
    repeat (90000) @(negedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    seed = 26;
    a_hi = 1'b0;
    a_lo = 1'b1;
    rst(1'b0);
    rst(1'b1);
    for (int i = 1; i < 5; i++) rd(8'(i));
    $display("test power-up done");
    for (int i = 0; i < 16; i++) begin
      a_hi = 1'($random(seed));
      a_lo = 1'($random(seed));
      wr(8'(i % 3 + 1), {1'($random(seed)), 4'(i), 3'(i)});
      wr(8'h04, 8'($random(seed)));
      rd(8'(i % 3 + 1));
    end
    rd(8'h04);
    $display("test field sweep done");
    wr(8'h05, 8'hFF);
    send({adr(1'b0) ^ 8'h02, 8'h01, 8'h07, 8'h00}, 3, 4'h0);
    chk_out();
    send({adr(1'b0), 8'h01, 8'h2E, 8'h7F}, 4, 4'hE);
    model[1] = 8'h2E;
    chk_out();
    rd(8'h01);
    $display("test refusals done");
    give_verdict();
  end
endmodule
